// ### audio_link_model.sv
// Audio controller model: free bit clock, frame sync, master reset.
// Assumes the codec samples the link on the rising bit clock.
`timescale 1ns/1ns
`default_nettype none
module audio_link_model (
    input  wire logic i_reset_req,
    input  wire logic i_sdata_in,
    output logic      o_bit_clk,
    output logic      o_sync,
    output logic      o_sdata_out,
    output logic      o_reset_n,
    output var int    o_tags
);
    logic [7:0] bit_count;
    assign o_reset_n = !i_reset_req;
    initial
    begin
        bit_count = 8'h0;
        o_tags = 0;
        o_sync = 1'b0;
        o_sdata_out = 1'b0;
        o_bit_clk = 1'b0;
        #1;
        forever #3 o_bit_clk = !o_bit_clk;
    end
    // Falling edge drive keeps clear of the codec's sampling edge
    always @(negedge o_bit_clk)
    begin
        bit_count <= bit_count + 8'h1;
        o_sync <= bit_count < 8'd16;
        o_sdata_out <= (bit_count == 8'h0) | bit_count[1];
    end
    always @(posedge o_bit_clk)
        if (i_sdata_in === 1'b1)
            o_tags <= o_tags + 1;
endmodule
`default_nettype wire

// ### codec_regs.sv
// Control register bank of a six-channel audio codec with its link front.
// Assumes a 100 MHz system clock, a 12.288 MHz bit clock from the link and
// the controller's active-low master reset arriving on a pin.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RQ1 - Reserved bits, unmapped and odd addresses read back as zero
// RQ2 - Digital output capability bit reads zero when its pin floats
// RQ3 - Two pulled-up select pins set this codec's position on the link
// RQ4 - Link bit clock 12.288 MHz, reference clock 24.576 MHz
// RQ5 - Controller drives a steady 48 kHz frame sync marking frames
// RQ6 - Active-low master reset returns all logic to its initial state
// RQ7 - Four 16-bit sample-rate registers in 1 Hz steps
// RQ8 - Index 00h shows enhancement code and capability flags, bit 15 zero
// RQ9 - Optional hardware mixdown of six channels to one stereo pair
// RQ10 - Amplifier power-down pin follows bit 15 of index 26h
// RQ11 - Indices 5Ah to 7Ah are maker registers for special functions
// RQ12 - Digital output carries linear PCM or compressed non-audio data
// RQ13 - Any write to index 00h restores every mixer register default
// RQ14 - Writes to reserved bits or unmapped addresses are ignored
// RQ15 - Identification and extended capability registers are read-only
module codec_regs
    import codec_regs_pkg::*;
#(
    // Arbitrary identity values
    parameter logic [4:0]  ENH_CODE  = 5'h0a,
    parameter logic [9:0]  CAP_FLAGS = 10'h0c5,
    parameter logic [15:0] ID_LOW    = 16'h1234,
    parameter logic [15:0] ID_HIGH   = 16'h5601
)(
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire bus_req_t      i_bus,
    output logic    [DW-1:0]   o_rdata,
    input  wire logic          i_reset_n,
    input  wire logic          i_bit_clk,
    input  wire logic          i_sync,
    input  wire logic          i_sdata_out,
    output logic               o_sdata_in,
    input  wire logic          i_codec_select_0,
    input  wire logic          i_codec_select_1,
    input  wire logic          i_spdif,
    output logic               o_spdif,
    output logic               o_spdif_oe_n,
    output logic               o_amp_powerdown,
    output logic               o_downmix,
    output logic               o_spdif_nonaudio
);

    initial
    begin
        if (FRAME_BITS != 256 || CRYSTAL_HZ != 2 * BIT_CLK_HZ)
            $error("codec_regs: unsupported clock ratios");
    end

    // Pin synchronisers in the system domain
    logic       prst_a;
    logic       prst_s;
    logic [1:0] sel_a;
    logic [1:0] sel_s;
    logic       spd_a;
    logic       spd_s;

    always_ff @(posedge i_clk)
    begin
        prst_a <= ~i_reset_n;
        prst_s <= prst_a;
        sel_a  <= {i_codec_select_1, i_codec_select_0};
        sel_s  <= sel_a;
        spd_a  <= i_spdif;
        spd_s  <= spd_a;
    end

    wire sys_rst = i_rst | prst_s; // RQ6

    // Floating pin pulls high, so only a loaded pin reports the output
    logic strap_done;
    logic spdif_present;

    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
        begin
            strap_done    <= 1'b0;
            spdif_present <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_done    <= 1'b1;
            spdif_present <= ~spd_s; // RQ2
        end
    end

    // Frame events from the link domain
    logic frame_tgl;
    logic ftgl_a;
    logic ftgl_s;
    logic ftgl_p;
    logic [15:0] frame_count;

    always_ff @(posedge i_clk)
    begin
        ftgl_a <= frame_tgl;
        ftgl_s <= ftgl_a;
        ftgl_p <= ftgl_s;
    end

    wire frame_evt = ftgl_s ^ ftgl_p;

    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
            frame_count <= 16'h0000;
        else if (frame_evt)
            frame_count <= frame_count + 16'h0001;
    end

    wire ready = (frame_count != 16'h0000);
    wire primary = (sel_s == 2'b00); // RQ3

    // Decode
    wire        bus_wr   = i_bus.wr;
    wire        bus_rd   = i_bus.rd;
    wire [6:0]  bus_addr = i_bus.addr;
    wire        odd_addr = bus_addr[0]; // RQ1
    wire        mixer_rst = bus_wr && !odd_addr
                          && (bus_addr == OFS_RESET); // RQ13

    logic [15:0] regs [NREG];
    logic [NREG-1:0] hit;
    logic [NREG-1:0] wr_ok;

    wire variable_rate_enable = regs[IDX_XCTL][VAR_RATE_BIT];

    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_reg
            localparam logic [15:0] WM = (g == IDX_XCTL && 1'b1)
                ? REG_MASK[g] : REG_MASK[g];
            wire is_rate = (g >= IDX_RATE0) && (g < IDX_RATE0 + 4);
            // Rate writes only land while variable rate is on
            assign hit[g]   = !odd_addr && (bus_addr == REG_OFS[g]);
            assign wr_ok[g] = bus_wr && hit[g]
                            && (!is_rate || variable_rate_enable); // RQ7
            wire [15:0] mask = (g == IDX_XCTL && !spdif_present)
                ? (REG_MASK[g] & ~(16'h0001 << SPDIF_BIT)) // RQ2
                : REG_MASK[g];

            always_ff @(posedge i_clk)
            begin
                if (sys_rst || mixer_rst) // RQ13
                    regs[g] <= REG_RST[g];
                else if (wr_ok[g])
                    regs[g] <= (i_bus.wdata & mask)
                             | (regs[g] & ~mask); // RQ14
            end
        end
    endgenerate

    // Read mux over storage
    logic [15:0] store_rd;

    always_comb
    begin
        store_rd = 16'h0000;
        for (int i = 0; i < NREG; i++)
            if (hit[i])
                store_rd = store_rd | (regs[i] & REG_MASK[i]); // RQ1
    end

    // Fixed and status views
    wire [15:0] reset_view = {1'b0, ENH_CODE, CAP_FLAGS}; // RQ8

    wire [15:0] xcap_view = {sel_s, 5'h00, 3'b111, 3'h0,
                             spdif_present, 1'b0, 1'b1}; // RQ15

    wire [15:0] pwr_view = (regs[IDX_PWR] & REG_MASK[IDX_PWR])
                         | {12'h000, {4{ready}}};

    wire spcv = regs[IDX_XCTL][SPDIF_BIT] & spdif_present;

    wire [15:0] xctl_view = (regs[IDX_XCTL] & REG_MASK[IDX_XCTL])
                          | (16'(spcv) << SPCV_BIT)
                          | {7'h00, {3{ready}}, 6'h00};

    wire is_rate_rd = !odd_addr && (bus_addr >= REG_OFS[IDX_RATE0])
                    && (bus_addr <= REG_OFS[IDX_RATE0 + 3]);

    // Fixed 48 kHz reads while variable rate is off
    wire [15:0] rate_view = variable_rate_enable
                          ? store_rd : RATE_48K; // RQ7

    logic [15:0] next_rdata;

    always_comb
    begin
        next_rdata = 16'h0000;
        if (odd_addr)
            next_rdata = 16'h0000; // RQ1
        else if (bus_addr == OFS_RESET)
            next_rdata = reset_view;
        else if (bus_addr == OFS_XCAP)
            next_rdata = xcap_view;
        else if (bus_addr == OFS_XCTL)
            next_rdata = xctl_view;
        else if (bus_addr == REG_OFS[IDX_PWR])
            next_rdata = pwr_view;
        else if (is_rate_rd)
            next_rdata = rate_view;
        else if (bus_addr == OFS_LINK)
            next_rdata = frame_count; // RQ11
        else if (bus_addr == OFS_ID_LO)
            next_rdata = ID_LOW; // RQ15
        else if (bus_addr == OFS_ID_HI)
            next_rdata = ID_HIGH; // RQ15
        else
            next_rdata = store_rd;
    end

    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
            o_rdata <= 16'h0000;
        else if (bus_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= 16'h0000;
    end

    // Control outputs
    wire spd_drive = spcv;

    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
        begin
            o_amp_powerdown  <= 1'b0;
            o_downmix        <= 1'b0;
            o_spdif_nonaudio <= 1'b0;
            o_spdif          <= 1'b0;
            o_spdif_oe_n     <= 1'b1;
        end
        else
        begin
            o_amp_powerdown  <= regs[IDX_PWR][AMP_PD_BIT]; // RQ10
            o_downmix        <= regs[IDX_MIX][DMIX_BIT]; // RQ9
            o_spdif_nonaudio <= regs[IDX_SPD][NONPCM_BIT]; // RQ12
            o_spdif          <= 1'b0;
            o_spdif_oe_n     <= ~spd_drive;
        end
    end

    // Tag level toward the link
    logic tag_en;

    always_ff @(posedge i_clk)
    begin
        if (sys_rst)
            tag_en <= 1'b0;
        else
            tag_en <= ready & primary; // RQ3
    end

    // Link domain, clocked by the bit clock
    logic               lrst_a;
    logic               lrst;
    logic               lsync_a;
    logic               lsync_s;
    logic               lsync_p;
    logic               lsdo_a;
    logic               lsdo_s;
    logic               ltag_a;
    logic               ltag_s;
    logic [FBITS_W-1:0] bit_cnt;

    always_ff @(posedge i_bit_clk)
    begin
        lrst_a  <= ~i_reset_n;
        lrst    <= lrst_a;
        lsync_a <= i_sync;
        lsync_s <= lsync_a;
        lsdo_a  <= i_sdata_out;
        lsdo_s  <= lsdo_a;
        ltag_a  <= tag_en;
        ltag_s  <= ltag_a;
    end

    // Frame boundary from the sync rising edge; link clock may stop
    wire frame_start = lsync_s & ~lsync_p; // RQ5

    always_ff @(posedge i_bit_clk)
    begin
        if (lrst) // RQ6
        begin
            lsync_p   <= 1'b0;
            bit_cnt   <= '0;
            frame_tgl <= 1'b0;
            o_sdata_in <= 1'b0;
        end
        else
        begin
            lsync_p <= lsync_s;
            // Bit count wraps once per 256-bit frame
            bit_cnt <= frame_start ? '0 : bit_cnt + 1'b1; // RQ4
            if (frame_start && lsdo_s)
                frame_tgl <= ~frame_tgl; // RQ5
            o_sdata_in <= frame_start & ltag_s;
        end
    end

endmodule

`default_nettype wire

// ### codec_regs_checker.sv
// Port assertions for the codec register bank.
// Bound to codec_regs from the bench top; system clock domain only.
`timescale 1ns/1ns
`default_nettype none
module codec_regs_checker
    import codec_regs_pkg::*;
#(
    parameter logic [4:0]  ENH_CODE  = 5'h0a,
    parameter logic [9:0]  CAP_FLAGS = 10'h0c5,
    parameter logic [15:0] ID_LOW    = 16'h1234,
    parameter logic [15:0] ID_HIGH   = 16'h5601
)(
    input wire logic          i_clk,
    input wire logic          i_rst,
    input wire bus_req_t      i_bus,
    input wire logic [DW-1:0] o_rdata,
    input wire logic          o_spdif_oe_n,
    input wire logic          o_amp_powerdown,
    input wire logic          o_downmix,
    input wire logic          o_spdif_nonaudio
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic       rd = i_bus.rd;
    wire logic [6:0] ad = i_bus.addr;

    a_idle_reads_zero: assert property (!rd |=> o_rdata == 16'h0)
        else $error("read data not zero outside a read answer");
    a_odd_addr_zero: assert property ($past(rd && ad[0]) |-> !(|o_rdata))
        else $error("odd address read not zero");
    a_ident_word: assert property (rd && ad == 7'h00 |=>
        o_rdata == {1'b0, ENH_CODE, CAP_FLAGS})
        else $error("capability word wrong");
    a_amp_pin_follows: assert property (rd && ad == 7'h26 |=>
        o_rdata[15] == o_amp_powerdown)
        else $error("amplifier pin differs from its control bit");
    a_downmix_follows: assert property (rd && ad == 7'h5e ##1 1 |->
        o_rdata[0] == o_downmix)
        else $error("downmix pin differs from its control bit");
    a_nonaudio_follows: assert property (rd && ad == 7'h3a |=>
        o_rdata[1] == o_spdif_nonaudio)
        else $error("non-audio pin differs from its control bit");
    a_spdif_enable_match: assert property (rd && ad == 7'h2a |=>
        o_rdata[2] != o_spdif_oe_n)
        else $error("digital output enable differs from its bit");
    a_id_low_fixed: assert property (rd && ad == 7'h7c |=>
        o_rdata == ID_LOW)
        else $error("low identity word changed");
    a_id_high_fixed: assert property (rd && ad == 7'h7e |=>
        o_rdata == ID_HIGH)
        else $error("high identity word changed");
endmodule
`default_nettype wire

// ### codec_regs_pkg.sv
// Constants, register map and bus carrier for the codec register bank.
// Assumes a single 100 MHz system clock and a bit-clocked serial link.
package codec_regs_pkg;
    // Clock figures in Hz, with frame length in bits and its counter width
    localparam int BIT_CLK_HZ = 12288000;
    localparam int CRYSTAL_HZ = 24576000;
    localparam int FRAME_HZ   = 48000;
    localparam int FRAME_BITS = BIT_CLK_HZ / FRAME_HZ;
    localparam int FBITS_W    = $clog2(FRAME_BITS);

    localparam int        AW        = 7;
    localparam int        DW        = 16;
    localparam logic [6:0] OFS_RESET = 7'h00;
    localparam logic [6:0] OFS_XCAP  = 7'h28;
    localparam logic [6:0] OFS_XCTL  = 7'h2a;
    localparam logic [6:0] OFS_LINK  = 7'h60;
    localparam logic [6:0] OFS_ID_LO = 7'h7c;
    localparam logic [6:0] OFS_ID_HI = 7'h7e;

    // Field positions and the fixed 48 kHz rate value
    localparam int AMP_PD_BIT = 15;
    localparam int SPDIF_BIT  = 2;
    localparam int VAR_RATE_BIT = 0;
    localparam int NONPCM_BIT = 1;
    localparam int DMIX_BIT   = 0;
    localparam int SPCV_BIT   = 10;
    localparam logic [15:0] RATE_48K = 16'hbb80;

    // Storage registers: offset, writable bits, reset value
    localparam int NREG = 27;
    localparam int IDX_PWR = 15;
    localparam int IDX_XCTL = 16;
    localparam int IDX_RATE0 = 17;
    localparam int IDX_SPD = 23;
    localparam int IDX_MIX = 26;
    localparam logic [6:0] REG_OFS [NREG] = '{
        7'h02, 7'h04, 7'h06, 7'h0a, 7'h0c, 7'h0e, 7'h10, 7'h12, 7'h14,
        7'h16, 7'h18, 7'h1a, 7'h1c, 7'h20, 7'h22, 7'h26, 7'h2a, 7'h2c,
        7'h2e, 7'h30, 7'h32, 7'h36, 7'h38, 7'h3a, 7'h5a, 7'h5c, 7'h5e};
    localparam logic [15:0] REG_MASK [NREG] = '{
        16'h9f1f, 16'h9f1f, 16'h801f, 16'h801e, 16'h801f, 16'h805f,
        16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h0707,
        16'h8f0f, 16'h2380, 16'h000f, 16'hff00, 16'h3835, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, 16'h9f9f, 16'h9f9f, 16'hffff,
        16'h9e0c, 16'h0001, 16'h0001};
    localparam logic [15:0] REG_RST [NREG] = '{
        16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8008, 16'h8008,
        16'h8808, 16'h8808, 16'h8808, 16'h8808, 16'h8808, 16'h0000,
        16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hbb80,
        16'hbb80, 16'hbb80, 16'hbb80, 16'h8080, 16'h8080, 16'h0000,
        16'h0000, 16'h0000, 16'h0000};

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } bus_req_t;
endpackage

// ### codec_regs_tb.sv
// Self-checking bench for the codec register bank.
// Assumes audio_link_model on the link and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module codec_regs_tb;
    import codec_regs_pkg::*;
    localparam logic [4:0]  ENH = 5'h0a; // Arbitrary
    localparam logic [9:0]  CAP = 10'h0c5; // Arbitrary
    localparam logic [15:0] IDL = 16'h1234; // Arbitrary
    localparam logic [15:0] IDH = 16'h5601; // Arbitrary
    logic          i_clk;
    logic          i_rst;
    bus_req_t      i_bus;
    logic [DW-1:0] o_rdata;
    logic          sp_pin, rst_req, bclk, sync, sdo, rst_n, sdi, oe_n;
    logic [2:0]    pins;
    logic [1:0]    csel;
    int            tags, fail_count, checked, i, k;
    logic [31:0]   seed = 32'hdcbeb9e0;
    logic [31:0]   r;
    logic [15:0]   shadow [NREG];
    logic [6:0]    holes [7] = '{7'h03, 7'h08, 7'h24, 7'h2d, 7'h40,
                                 7'h7a, 7'h7f};
    logic [6:0]    pa [3] = '{7'h26, 7'h5e, 7'h3a};
    logic [15:0]   pd [3] = '{16'h8000, 16'h0001, 16'h0002};

    codec_regs #(.ENH_CODE(ENH), .CAP_FLAGS(CAP), .ID_LOW(IDL),
        .ID_HIGH(IDH)) i_codec_regs (.i_clk(i_clk), .i_rst(i_rst),
        .i_bus(i_bus), .o_rdata(o_rdata), .i_reset_n(rst_n),
        .i_bit_clk(bclk), .i_sync(sync), .i_sdata_out(sdo),
        .o_sdata_in(sdi), .i_codec_select_0(csel[0]),
        .i_codec_select_1(csel[1]), .i_spdif(sp_pin), .o_spdif(),
        .o_spdif_oe_n(oe_n), .o_amp_powerdown(pins[0]),
        .o_downmix(pins[1]), .o_spdif_nonaudio(pins[2]));
    audio_link_model i_audio_link_model (.i_reset_req(rst_req),
        .i_sdata_in(sdi), .o_bit_clk(bclk), .o_sync(sync),
        .o_sdata_out(sdo), .o_reset_n(rst_n), .o_tags(tags));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] cap28(input logic [1:0] sel,
                                          input logic pres);
        return {sel, 5'h0, 3'b111, 3'b000, pres, 1'b0, 1'b1};
    endfunction
    function automatic logic plain(input int n);
        return n < 15 || n > 20;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
    endtask
    task automatic rc(input logic [6:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        @(posedge i_clk);
        i_bus <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        chk(o_rdata & m, e);
    endtask
    // Strap is set well before release so the pin sampler sees it
    task automatic do_reset(input logic sp);
        sp_pin <= sp;
        i_rst <= 1'b1;
        rst_req <= 1'b1;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        rst_req <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (i = 0; i < NREG; i++)
            shadow[i] = REG_RST[i];
    endtask
    task automatic report_and_stop();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = !i_clk;
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        i_bus = '0;
        i_rst = 1'b1;
        rst_req = 1'b1;
        sp_pin = 1'b0;
        csel = 2'b00;
        fail_count = 0;
        checked = 0;
        do_reset(1'b0);
        rc(7'h00, {1'b0, ENH, CAP}, 16'hffff);
        wr(7'h7c, 16'hffff);
        wr(7'h7e, 16'h0000);
        wr(7'h28, 16'h0000);
        rc(7'h7c, IDL, 16'hffff);
        rc(7'h7e, IDH, 16'hffff);
        rc(7'h28, cap28(2'b00, 1'b1), 16'hffff);
        for (k = 0; k < 7; k++)
        begin
            wr(holes[k], 16'(xs() | 32'h1));
            rc(holes[k], 16'h0, 16'hffff);
        end
        repeat (80)
        begin
            r = xs();
            i = r[31:16] % NREG;
            if (plain(i))
            begin
                wr(REG_OFS[i], r[15:0]);
                shadow[i] = r[15:0] & REG_MASK[i];
            end
        end
        for (k = 0; k < NREG; k++)
            if (plain(k))
                rc(REG_OFS[k], shadow[k], 16'hffff);
        wr(7'h00, 16'(xs()));
        for (k = 0; k < NREG; k++)
            if (plain(k))
                rc(REG_OFS[k], REG_RST[k], 16'hffff);
        wr(7'h2c, 16'h1234);
        rc(7'h2c, RATE_48K, 16'hffff);
        wr(7'h2a, 16'h0005);
        for (k = 0; k < 4; k++)
        begin
            r = xs();
            wr(7'h2c + 7'(2 * k), r[15:0]);
            rc(7'h2c + 7'(2 * k), r[15:0], 16'hffff);
        end
        for (k = 0; k < 6; k++)
        begin
            wr(pa[k % 3], (k < 3) ? pd[k % 3] : 16'h0);
            repeat (2) @(posedge i_clk);
            #1;
            chk({15'h0, pins[k % 3]}, {15'h0, k < 3});
            rc(pa[k % 3], (k < 3) ? pd[k % 3] : 16'h0, pd[k % 3]);
        end
        repeat (600) @(posedge i_clk);
        rc(7'h26, 16'h000f, 16'h000f);
        chk({15'h0, tags > 0}, 16'h0001);
        rc(7'h2a, 16'h0004, 16'h0004);
        chk({15'h0, oe_n}, 16'h0000);
        // Second position must never answer with the ready tag
        csel <= 2'b10;
        do_reset(1'b1);
        rc(7'h28, cap28(2'b10, 1'b0), 16'hffff);
        rc(7'h02, 16'h8000, 16'hffff);
        wr(7'h2a, 16'h0005);
        rc(7'h2a, 16'h0001, 16'h0005);
        chk({15'h0, oe_n}, 16'h0001);
        k = tags;
        repeat (400) @(posedge i_clk);
        rc(7'h26, 16'h000f, 16'h000f);
        chk({15'h0, tags == k}, 16'h0001);
        report_and_stop();
    end
endmodule

bind codec_regs codec_regs_checker #(.ENH_CODE(ENH_CODE),
    .CAP_FLAGS(CAP_FLAGS), .ID_LOW(ID_LOW), .ID_HIGH(ID_HIGH))
    i_codec_regs_checker (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_spdif_oe_n(o_spdif_oe_n),
    .o_amp_powerdown(o_amp_powerdown), .o_downmix(o_downmix),
    .o_spdif_nonaudio(o_spdif_nonaudio));
`default_nettype wire
